// File: rtl/cid_top.v
// Top-level halfword decoder with AXI4-Lite control and branch-target handling
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.

`include "cid_defines.vh"

module cid_top
(
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Halfword stream from fetch
  input  wire        hw_valid,
  input  wire [15:0] hw_data,
  input  wire        hw_flush,
  // Decoded instruction to execute
  output reg         dec_valid_r,
  output reg         dec_is_long_r,
  output reg  [31:0] dec_word_r,
  output reg  [1:0]  dec_class_r,
  output reg  [3:0]  dec_group_r,
  output reg  [3:0]  dec_op_r,
  output reg  [2:0]  dec_rd_r,
  output reg  [2:0]  first_src_reg_field_r,
  output reg  [2:0]  second_src_reg_field_r,
  output reg  [2:0]  imm_three_bit_r,
  output reg  [7:0]  imm_eight_bit_r,
  output reg         dec_hint_r,
  output reg         dec_undef_r,
  output reg         invalid_state_fault_r,
  // Branch target from execute
  input  wire        br_valid,
  input  wire [2:0]  br_kind,
  input  wire [31:0] br_target,
  // Architectural state
  output reg  [31:0] pc_r,
  output reg         exec_state_isa_bit_r,
  output reg         secure_state_r,
  output reg         irq_r,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ---------------------------------------------------------------
  // Halfword assembly
  // ---------------------------------------------------------------
  reg        pend_r;
  reg [15:0] lead_r;
  reg [1:0]  ctrl_r;
  reg [`CID_IRQ_WIDTH-1:0] irq_stat_r;
  reg [`CID_IRQ_WIDTH-1:0] irq_mask_r;
  reg        fault_arm_r;

  wire [4:0] top5    = hw_data[15:11];
  wire       is_lead = (top5 == `CID_PFX_A) || (top5 == `CID_PFX_B) ||
                       (top5 == `CID_PFX_C);
  wire       take    = hw_valid && !hw_flush;
  wire       emit    = take && (pend_r || !is_lead);
  wire [31:0] word   = pend_r ? {lead_r, hw_data} : {16'h0000, hw_data};

  // Pending leading half; a flush drops it so stale halves never pair
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_r <= 1'b0;
      lead_r <= 16'h0000;
    end
    else if (hw_flush)
      pend_r <= 1'b0;
    else if (take)
    begin
      if (pend_r)
        pend_r <= 1'b0;
      else if (is_lead)
      begin
        pend_r <= 1'b1;
        lead_r <= hw_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Combinational decode
  // ---------------------------------------------------------------
  reg [1:0] cls_nxt;
  reg [3:0] grp_nxt;
  reg [3:0] op_nxt;
  reg [2:0] rd_nxt;
  reg [2:0] rn_nxt;
  reg [2:0] rm_nxt;
  reg [2:0] i3_nxt;
  reg [7:0] i8_nxt;
  reg       hint_nxt;
  reg       undef_nxt;
  reg [15:0] h;
  reg [5:0]  primary_opcode_field;

  // Group and operation decode of the halfword being emitted
  always @*
  begin
    h = pend_r ? lead_r : hw_data;
    primary_opcode_field = h[15:10];
    cls_nxt   = `CID_CLS_SHORT;
    grp_nxt   = `CID_GRP_NONE;
    op_nxt    = `CID_OP_NONE;
    rd_nxt    = h[2:0];
    rn_nxt    = h[5:3];
    rm_nxt    = h[8:6];
    i3_nxt    = h[8:6];
    i8_nxt    = h[7:0];
    hint_nxt  = 1'b0;
    undef_nxt = 1'b0;
    if (h[15:13] != 3'h7)
    begin
      // Short group
      casez (primary_opcode_field)
        6'b00????: grp_nxt = `CID_GRP_SAMC;
        6'b010000: grp_nxt = `CID_GRP_DP2;
        6'b010001: grp_nxt = `CID_GRP_SPECIAL;
        6'b01001?: grp_nxt = `CID_GRP_LIT_LOAD;
        6'b0101??: grp_nxt = `CID_GRP_LS_REG;
        6'b011???: grp_nxt = `CID_GRP_LS_WB;
        6'b1000??: grp_nxt = `CID_GRP_LS_HALF;
        6'b1001??: grp_nxt = `CID_GRP_LS_SP;
        6'b1010??: grp_nxt = `CID_GRP_ADR;
        6'b1011??: grp_nxt = `CID_GRP_MISC;
        6'b1100??: grp_nxt = `CID_GRP_LDSTM;
        6'b1101??: grp_nxt = `CID_GRP_CBR_SVC;
        default:   grp_nxt = `CID_GRP_NONE;
      endcase
      // Sub-decode by tertiary, secondary and primary fields
      if (grp_nxt == `CID_GRP_SAMC)
      begin
        if (h[13])
        begin
          rd_nxt = h[10:8];
          case (h[12:11])
            2'h0:    op_nxt = `CID_OP_MOV_IMM;
            2'h1:    op_nxt = `CID_OP_CMP_IMM;
            2'h2:    op_nxt = `CID_OP_ADD_IMM_EIGHT_BIT;
            default: op_nxt = `CID_OP_SUB_IMM_EIGHT_BIT;
          endcase
        end
        else if (h[12:11] == 2'h3 && !h[10])
          op_nxt = h[9] ? `CID_OP_SUB_REG : `CID_OP_ADD_REG;
        else if (h[12:11] == 2'h3)
          op_nxt = h[9] ? `CID_OP_SUB_IMM_THREE_BIT : `CID_OP_ADD_IMM_THREE_BIT;
        else
          op_nxt = `CID_OP_MOV_SHIFT;
      end
      // Short hints: no operation is carried out
      if (h[15:8] == `CID_HINT16_HI && h[3:0] == 4'h0)
        hint_nxt = 1'b1;
      // State-changing register branches need the Secure bit of the control register set
      if (grp_nxt == `CID_GRP_SPECIAL && h[9:8] == 2'h3 && h[2] &&
          !ctrl_r[`CID_CTRL_SECURE_BIT])
        undef_nxt = 1'b1;
    end
    else if (h[12:11] == 2'h0)
      cls_nxt = `CID_CLS_WIDE_BR;
    else
    begin
      cls_nxt = `CID_CLS_LONG;
      // Long hints only exist with the main feature set
      if (h == `CID_HINT32_HW0 && hw_data[15:11] == `CID_HINT32_HW1HI)
      begin
        hint_nxt  = ctrl_r[`CID_CTRL_MAIN_BIT];
        undef_nxt = !ctrl_r[`CID_CTRL_MAIN_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dec_valid_r <= 1'b0;
      dec_is_long_r <= 1'b0;
      dec_word_r <= 32'h00000000;
      dec_class_r <= 2'h0;
      dec_group_r <= 4'h0;
      dec_op_r <= 4'h0;
      dec_rd_r <= 3'h0;
      first_src_reg_field_r <= 3'h0;
      second_src_reg_field_r <= 3'h0;
      imm_three_bit_r <= 3'h0;
      imm_eight_bit_r <= 8'h00;
      dec_hint_r <= 1'b0;
      dec_undef_r <= 1'b0;
      invalid_state_fault_r <= 1'b0;
    end
    else
    begin
      dec_valid_r <= emit;
      invalid_state_fault_r <= emit && fault_arm_r;
      if (emit)
      begin
        dec_is_long_r <= pend_r;
        dec_word_r <= word;
        dec_class_r <= cls_nxt;
        dec_group_r <= grp_nxt;
        dec_op_r <= op_nxt;
        dec_rd_r <= rd_nxt;
        first_src_reg_field_r <= rn_nxt;
        second_src_reg_field_r <= rm_nxt;
        imm_three_bit_r <= i3_nxt;
        imm_eight_bit_r <= i8_nxt;
        dec_hint_r <= hint_nxt;
        dec_undef_r <= undef_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // Branch target handling
  // ---------------------------------------------------------------
  wire br_inter = (br_kind == `CID_BR_REG) || (br_kind == `CID_BR_REG_LINK) ||
                  (br_kind == `CID_BR_POP_PC) || (br_kind == `CID_BR_LDM_PC) ||
                  (br_kind == `CID_BR_LOAD_PC);
  wire br_ns    = (br_kind == `CID_BR_TO_NS) || (br_kind == `CID_BR_LINK_NS);
  wire br_ok    = br_valid && (br_inter || (br_ns && secure_state_r));
  wire ev_fault = br_valid && br_inter && !br_target[0];
  wire ev_undef = br_valid && br_ns && !secure_state_r;

  // Write-side holding state, declared here because the state process reads it
  reg        aw_hold_r;
  reg        w_hold_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  wire       wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire [31:0] wdat = wdata_r;
  wire       wr_ctrl = wr_go && (awaddr_r == `CID_CTRL_OFF) && wstrb_r[0];
  wire [`CID_IRQ_WIDTH-1:0] ev_vec = {emit && hint_nxt, ev_undef, ev_fault};
  wire [`CID_IRQ_WIDTH-1:0] w1c = (wr_go && awaddr_r == `CID_IRQ_STAT_OFF &&
                                   wstrb_r[0]) ? wdat[`CID_IRQ_WIDTH-1:0] : 3'h0;

  // Target bit 0 never reaches the program counter
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pc_r <= 32'h00000000;
      exec_state_isa_bit_r <= 1'b1;
      secure_state_r <= 1'b1;
      fault_arm_r <= 1'b0;
    end
    else
    begin
      if (br_ok)
        pc_r <= {br_target[31:1], 1'b0};
      if (br_valid && br_inter)
      begin
        exec_state_isa_bit_r <= br_target[0];
        fault_arm_r <= !br_target[0];
      end
      else if (emit)
        fault_arm_r <= 1'b0;                                   // Fault taken once
      if (br_valid && br_ns && secure_state_r)
        secure_state_r <= br_target[0];
      else if (wr_ctrl)
        secure_state_r <= wdat[`CID_CTRL_SECURE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------

  // Write channel: address and data taken independently, then answered
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl_r <= `CID_CTRL_RESET;
      irq_mask_r <= 3'h0;
      irq_stat_r <= 3'h0;
    end
    else
    begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r == `CID_CTRL_OFF || awaddr_r == `CID_IRQ_STAT_OFF ||
            awaddr_r == `CID_IRQ_MASK_OFF)
          s_axi_bresp <= 2'h0;
        else if (awaddr_r == `CID_STATUS_OFF || awaddr_r == `CID_BRANCH_OFF ||
                 awaddr_r == `CID_PC_OFF)
          s_axi_bresp <= 2'h0;
        else
          s_axi_bresp <= 2'h2;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_ctrl)
        ctrl_r <= wdat[1:0];
      if (wr_go && awaddr_r == `CID_IRQ_MASK_OFF && wstrb_r[0])
        irq_mask_r <= wdat[`CID_IRQ_WIDTH-1:0];
      // Set wins over a simultaneous write-one clear
      irq_stat_r <= (irq_stat_r & ~w1c) | ev_vec;
    end
  end

  // Read channel and interrupt output
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= |(irq_stat_r & irq_mask_r);
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        if (s_axi_araddr == `CID_CTRL_OFF)
          s_axi_rdata <= {30'h0, ctrl_r[1], ctrl_r[0]};
        else if (s_axi_araddr == `CID_STATUS_OFF)
          s_axi_rdata <= {28'h0, pend_r, fault_arm_r, secure_state_r,
                          exec_state_isa_bit_r};
        else if (s_axi_araddr == `CID_IRQ_STAT_OFF)
          s_axi_rdata <= {29'h0, irq_stat_r};
        else if (s_axi_araddr == `CID_IRQ_MASK_OFF)
          s_axi_rdata <= {29'h0, irq_mask_r};
        else if (s_axi_araddr == `CID_BRANCH_OFF)
          s_axi_rdata <= dec_word_r;
        else if (s_axi_araddr == `CID_PC_OFF)
          s_axi_rdata <= pc_r;
        else
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: rtl/cid_defines.vh
// Constants for the compact instruction top-level decoder
`ifndef CID_DEFINES_VH
`define CID_DEFINES_VH

// Register byte offsets
`define CID_CTRL_OFF      8'h00
`define CID_STATUS_OFF    8'h04
`define CID_IRQ_STAT_OFF  8'h08
`define CID_IRQ_MASK_OFF  8'h0C
`define CID_BRANCH_OFF    8'h10
`define CID_PC_OFF        8'h14

// Control fields
`define CID_CTRL_MAIN_BIT    0
`define CID_CTRL_SECURE_BIT  1
`define CID_CTRL_RESET       2'h3

// Interrupt status bits
`define CID_IRQ_FAULT_BIT    0
`define CID_IRQ_UNDEF_BIT    1
`define CID_IRQ_HINT_BIT     2
`define CID_IRQ_WIDTH        3

// Long-instruction prefixes (bits 15:11)
`define CID_PFX_A         5'h1D
`define CID_PFX_B         5'h1E
`define CID_PFX_C         5'h1F

// Top-level class codes
`define CID_CLS_SHORT     2'h0
`define CID_CLS_WIDE_BR   2'h1
`define CID_CLS_LONG      2'h2

// Short-group codes
`define CID_GRP_SAMC      4'h0
`define CID_GRP_DP2       4'h1
`define CID_GRP_SPECIAL   4'h2
`define CID_GRP_LIT_LOAD  4'h3
`define CID_GRP_LS_REG    4'h4
`define CID_GRP_LS_WB     4'h5
`define CID_GRP_LS_HALF   4'h6
`define CID_GRP_LS_SP     4'h7
`define CID_GRP_ADR       4'h8
`define CID_GRP_MISC      4'h9
`define CID_GRP_LDSTM     4'hA
`define CID_GRP_CBR_SVC   4'hB
`define CID_GRP_NONE      4'hF

// Operation codes inside the shift/add/sub/move/compare group
`define CID_OP_NONE       4'h0
`define CID_OP_ADD_REG    4'h1
`define CID_OP_SUB_REG    4'h2
`define CID_OP_ADD_IMM_THREE_BIT   4'h3
`define CID_OP_SUB_IMM_THREE_BIT   4'h4
`define CID_OP_MOV_SHIFT  4'h5
`define CID_OP_MOV_IMM    4'h6
`define CID_OP_CMP_IMM    4'h7
`define CID_OP_ADD_IMM_EIGHT_BIT   4'h8
`define CID_OP_SUB_IMM_EIGHT_BIT   4'h9

// Branch kinds written by execute: interworking (0 to 4) and non-secure state (5, 6)
`define CID_BR_REG        3'h0
`define CID_BR_REG_LINK   3'h1
`define CID_BR_POP_PC     3'h2
`define CID_BR_LDM_PC     3'h3
`define CID_BR_LOAD_PC    3'h4
`define CID_BR_TO_NS      3'h5
`define CID_BR_LINK_NS    3'h6

// Hint encodings recognised at this level
`define CID_HINT16_HI     8'hBF
`define CID_HINT32_HW0    16'hF3AF
`define CID_HINT32_HW1HI  5'h10

`endif

// File: testbench/cid_top_asserts.sv
// Assertion checker for the halfword decoder, bound to its top module
module cid_top_asserts
(
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Halfword stream
  input wire        hw_valid,
  input wire [15:0] hw_data,
  input wire        hw_flush,
  // Decoder result
  input wire        dec_valid_r,
  input wire        dec_is_long_r,
  input wire [31:0] dec_word_r,
  input wire [1:0]  dec_class_r,
  input wire [3:0]  dec_group_r,
  input wire [3:0]  dec_op_r,
  // Branch and state
  input wire        br_valid,
  input wire [2:0]  br_kind,
  input wire [31:0] br_target,
  input wire [31:0] pc_r,
  input wire        exec_state_isa_bit_r,
  input wire        secure_state_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Reference decode and pending leader
  // ----------------------------------------
  logic        pend_r, pend_nxt;
  logic [15:0] lead_r, lead_nxt;
  wire         take = hw_valid && !hw_flush;
  wire         is_lead = hw_data[15:11] >= 5'h1D;
  wire         tgt0 = br_target[0];
  wire         ns_br = br_valid && (br_kind == 3'h5 || br_kind == 3'h6);
  wire  [15:0] fh = dec_is_long_r ? dec_word_r[31:16] : dec_word_r[15:0];
  wire  [1:0]  cls = fh[15:13] != 3'h7 ? 2'h0 : (fh[12:11] == 2'h0 ? 2'h1 : 2'h2);

  // Group from the six top bits; F covers everything outside the short set
  function automatic [3:0] grp(input [5:0] o);
    casez (o)
      6'b00????: grp = 4'h0;
      6'b010000: grp = 4'h1;
      6'b010001: grp = 4'h2;
      6'b01001?: grp = 4'h3;
      6'b0101??: grp = 4'h4;
      6'b011???: grp = 4'h5;
      6'b1000??: grp = 4'h6;
      6'b1001??: grp = 4'h7;
      6'b1010??: grp = 4'h8;
      6'b1011??: grp = 4'h9;
      6'b1100??: grp = 4'hA;
      6'b1101??: grp = 4'hB;
      default:   grp = 4'hF;
    endcase
  endfunction

  // Operation inside the shift/add/sub/move/compare group
  function automatic [3:0] sop(input [15:0] w);
    if (w[15:13] == 3'h1)
      sop = 4'h6 + {2'h0, w[12:11]};
    else if (w[15:13] != 3'h0)
      sop = 4'h0;
    else if (w[12:11] != 2'h3)
      sop = 4'h5;
    else
      sop = 4'h1 + {2'h0, w[10], w[9]};
  endfunction

  // Leader tracking; a flush drops a held leader
  always @*
  begin
    pend_nxt = pend_r;
    lead_nxt = lead_r;
    if (hw_flush)
      pend_nxt = 1'b0;
    else if (take)
    begin
      pend_nxt = !pend_r && is_lead;
      lead_nxt = hw_data;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_r <= 1'b0;
      lead_r <= 16'h0000;
    end
    else
    begin
      pend_r <= pend_nxt;
      lead_r <= lead_nxt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence short_take;
    take && !pend_r && !is_lead;
  endsequence
  sequence second_take;
    take && pend_r;
  endsequence

  short_out_a: assert property (short_take |=> dec_valid_r && !dec_is_long_r
    && dec_word_r == {16'h0000, $past(hw_data)}) else $error("short word wrong");
  long_out_a: assert property (second_take |=> dec_valid_r && dec_is_long_r
    && dec_word_r == {$past(lead_r), $past(hw_data)}) else $error("long word wrong");
  lead_hold_a: assert property ((!take || (!pend_r && is_lead)) |=> !dec_valid_r)
    else $error("output without complete instruction");
  class_sel_a: assert property (dec_valid_r |-> dec_class_r == cls)
    else $error("class wrong");
  group_sel_a: assert property (dec_valid_r && !dec_is_long_r
    |-> dec_group_r == grp(dec_word_r[15:10])) else $error("group wrong");
  samc_op_a: assert property (dec_valid_r && !dec_is_long_r
    |-> dec_op_r == sop(dec_word_r[15:0])) else $error("operation wrong");
  pc_bit0_a: assert property (pc_r[0] == 1'b0) else $error("pc bit 0 set");
  iw_branch_a: assert property (br_valid && br_kind <= 3'h4 |=>
    pc_r == ($past(br_target) & 32'hFFFFFFFE) && exec_state_isa_bit_r == $past(tgt0))
    else $error("interworking branch wrong");
  ns_state_a: assert property (ns_br && secure_state_r |=> secure_state_r == $past(tgt0))
    else $error("security state wrong");
  ns_undef_a: assert property (ns_br && !secure_state_r |=> $stable(pc_r) && !secure_state_r)
    else $error("non-secure state branch took effect");
endmodule

bind cid_top cid_top_asserts u_chk (.*);

// File: testbench/cid_fetch_model.sv
// Fetch and execute side model: halfword stream and branch results
module cid_fetch_model
(
  // Clock
  input  wire         aclk,
  // Halfword stream
  output logic        hw_valid,
  output logic [15:0] hw_data,
  output logic        hw_flush,
  // Branch results
  output logic        br_valid,
  output logic [2:0]  br_kind,
  output logic [31:0] br_target
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle values at time zero
  initial
  begin
    hw_valid = 1'b0;
    hw_data = 16'h0000;
    hw_flush = 1'b0;
    br_valid = 1'b0;
    br_kind = 3'h0;
    br_target = 32'h0000_0000;
  end

  // One halfword; with last clear the next one follows back to back
  task send(input logic [15:0] h, input bit last);
    @(posedge aclk);
    hw_valid <= 1'b1;
    hw_data <= h;
    if (last)
    begin
      @(posedge aclk);
      hw_valid <= 1'b0;
      hw_data <= ~h; // Stale data must not look valid
    end
  endtask

  // One-cycle flush pulse
  task flush;
    @(posedge aclk);
    hw_flush <= 1'b1;
    @(posedge aclk);
    hw_flush <= 1'b0;
  endtask

  // One branch result from execute
  task branch(input logic [2:0] k, input logic [31:0] t);
    @(posedge aclk);
    br_valid <= 1'b1;
    br_kind <= k;
    br_target <= t;
    @(posedge aclk);
    br_valid <= 1'b0;
    br_target <= ~t;
  endtask
endmodule

// File: testbench/cid_top_tb.sv
// Self-checking testbench for the halfword decoder
module cid_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        aclk, aresetn;
  wire         hw_valid, hw_flush, br_valid;
  wire  [15:0] hw_data;
  wire  [2:0]  br_kind, dec_rd_r, first_src_reg_field_r, second_src_reg_field_r, imm_three_bit_r;
  wire  [31:0] br_target, dec_word_r, pc_r, s_axi_rdata;
  wire         dec_valid_r, dec_is_long_r, dec_hint_r, dec_undef_r, invalid_state_fault_r;
  wire         exec_state_isa_bit_r, secure_state_r, irq_r;
  wire  [1:0]  dec_class_r, s_axi_bresp, s_axi_rresp;
  wire  [3:0]  dec_group_r, dec_op_r;
  wire  [7:0]  imm_eight_bit_r;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  rsp;
  int          bad_count, checks;

  cid_top dut (.*);
  cid_fetch_model fm (.*);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task finish_test;
    $display("mismatches %0d comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Bounded wait for the decoded pulse, sampled mid-cycle
  task wait_dec;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge aclk);
      if (dec_valid_r === 1'b1) break;
    end
    cmp(dec_valid_r, 1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    axi_rd(8'h14);
    cmp(rd, 0);
    axi_rd(8'h40);
    cmp(rsp, 2);
    axi_wr(8'h40, 32'h0000_0001);
    cmp(rsp, 2);
  endtask

  // Top end of every short opcode range
  task t_groups;
    logic [15:0] h [12];
    h = '{16'h3FFF, 16'h43FF, 16'h47FF, 16'h4FFF, 16'h5FFF, 16'h7FFF,
          16'h8FFF, 16'h9FFF, 16'hAFFF, 16'hBFFF, 16'hCFFF, 16'hDFFF};
    for (int i = 0; i < 12; i++)
    begin
      fm.send(h[i], 1);
      wait_dec;
      cmp(dec_group_r, i);
      cmp(dec_word_r, {16'h0000, h[i]});
    end
  endtask

  task t_ops;
    logic [15:0] h [9];
    h = '{16'h1888, 16'h1A88, 16'h1C88, 16'h1E88, 16'h0888,
          16'h2155, 16'h2955, 16'h3155, 16'h3955};
    for (int i = 0; i < 9; i++)
    begin
      fm.send(h[i], 1);
      wait_dec;
      cmp(dec_op_r, i + 1);
      if (i == 0) cmp({dec_rd_r, first_src_reg_field_r, second_src_reg_field_r}, 9'h00A);
      if (i == 2) cmp({imm_three_bit_r, first_src_reg_field_r}, 6'h11);
      if (i == 8) cmp({dec_rd_r, imm_eight_bit_r}, 11'h155);
    end
  endtask

  // Second half repeats a leader pattern; it must still pair
  task t_long;
    logic [15:0] p [3];
    p = '{16'hE800, 16'hF000, 16'hF800};
    for (int i = 0; i < 3; i++)
    begin
      fm.send(p[i], 0);
      fm.send(p[i], 1);
      wait_dec;
      cmp({dec_class_r, dec_is_long_r}, 3'h5);
      cmp(dec_word_r, {p[i], p[i]});
    end
    fm.send(16'hE000, 1);
    wait_dec;
    cmp({dec_class_r, dec_is_long_r}, 3'h2);
    fm.send(16'hF000, 1);
    fm.flush;
    fm.send(16'h1888, 1);
    wait_dec;
    cmp(dec_word_r, 32'h0000_1888);
  endtask

  task t_hint;
    fm.send(16'hBF10, 1);
    wait_dec;
    cmp(dec_hint_r, 1);
    for (int m = 1; m >= 0; m--)
    begin
      axi_wr(8'h00, {30'h0, 1'b1, m[0]});
      fm.send(16'hF3AF, 0);
      fm.send(16'h8000, 1);
      wait_dec;
      cmp({dec_hint_r, dec_undef_r}, m ? 2'h2 : 2'h1);
    end
    axi_wr(8'h00, 32'h0000_0003);
    // Interrupt: raised only when unmasked, cleared by writing one
    axi_rd(8'h08);
    cmp({irq_r, rd[2]}, 2'h1);
    axi_wr(8'h0C, 32'h0000_0004);
    repeat (3) @(negedge aclk);
    cmp(irq_r, 1);
    axi_wr(8'h08, 32'h0000_0004);
    repeat (3) @(negedge aclk);
    axi_rd(8'h08);
    cmp({irq_r, rd[2]}, 2'h0);
  endtask

  task t_branch;
    for (int k = 0; k < 5; k++)
    begin
      fm.branch(k[2:0], 32'h100 * (k + 1) + 1);
      @(negedge aclk);
      cmp(pc_r, 32'h100 * (k + 1));
      cmp(exec_state_isa_bit_r, 1);
    end
    fm.branch(3'h4, 32'h0000_2000);
    @(negedge aclk);
    cmp(exec_state_isa_bit_r, 0);
    fm.send(16'h1888, 1);
    wait_dec;
    cmp(invalid_state_fault_r, 1);
    fm.branch(3'h0, 32'h0000_0011);
    fm.branch(3'h6, 32'h0000_0601);
    @(negedge aclk);
    cmp({secure_state_r, pc_r[0]}, 2'h2);
    fm.branch(3'h5, 32'h0000_0700);
    @(negedge aclk);
    cmp(secure_state_r, 0);
    fm.branch(3'h5, 32'h0000_0801);
    @(negedge aclk);
    cmp(pc_r, 32'h0000_0700);
    axi_rd(8'h08);
    cmp(rd[1], 1);
    axi_wr(8'h00, 32'h0000_0003);
  endtask

  // ----------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial
  begin
    #100000;
    bad_count++;
    finish_test;
  end

  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_groups;
    t_ops;
    t_long;
    t_hint;
    t_branch;
    finish_test;
  end
endmodule
